// [logic/lbmd_bus_master.sv]
// lbmd_bus_master: local bus master dma between the 16-byte fifo and buffer memory.
// assumes all inputs synchronous to clock_i and a request/grant bus arbiter.
// How it works
// RULE_01 - after reset: slave, reset state, receive and transmit disabled
// RULE_02 - stop, reset input or fifo over/underflow return to reset state
// RULE_03 - start enters idle; idle left only on fifo or remote request
// RULE_04 - every transfer requests the bus, waits for grant, then back to idle
// RULE_05 - 16 or 32 bit addressing combined with 8 or 16 bit data
// RULE_06 - each bus transfer takes four bus clocks
// RULE_07 - 32-bit mode: extra four-clock upper address cycle per burst
// RULE_08 - upper address strobe released after that first address cycle
// RULE_09 - burst moves exactly the configured length, then releases the bus
// RULE_10 - next burst waits for threshold again, or drain/fill option
// RULE_11 - grant withdrawn mid-transfer aborts the burst
// RULE_12 - local dma has priority; remote rearbitrates afterwards
// RULE_13 - request kept when local appends to remote; dropped local to remote
// RULE_14 - 16-byte fifo; local dma triggered by the fill threshold
// RULE_15 - receive: full 8-byte address field gathered before first request
// RULE_16 - first receive request no sooner than 7.8 us after frame start
// RULE_17 - carrier loss: finish burst, flush fifo, write 4-byte header, release
// RULE_18 - end of packet processing time follows burst and header sequence
// RULE_19 - overrun flagged when the thirteenth byte is written
// RULE_20 - request at n+1 bytes in byte mode, n+2 in word mode
// RULE_21 - transmit prefetches threshold bytes, then waits for frame start
// RULE_22 - arbiter grants within tolerated latency to avoid under/overrun
// RULE_23 - grant sampled on clock; first bus state on following cycle
`timescale 1ns/100ps
module lbmd_bus_master (
    input wire logic clock_i, // local bus clock
    input wire logic rstn_i, // synchronous reset, active low
    input wire logic start_cmd_i, // start command pulse
    input wire logic stop_cmd_i, // stop command pulse
    input wire logic cfg_addr32_i, // data_config_reg: 32-bit address
    input wire logic cfg_word_i, // data_config_reg: 16-bit data
    input wire logic [1:0] cfg_fifo_sel_i, // data_config_reg: threshold and burst
    input wire logic cfg_drain_all_i, // empty or fill fifo per acquisition
    input wire logic [7:0] remote_start_addr_low_i, // upper address bits 7:0
    input wire logic [7:0] remote_start_addr_high_i, // upper address bits 15:8
    input wire logic [15:0] local_base_i, // packet start in buffer memory
    input wire logic carrier_sense_i, // receive carrier
    input wire logic rx_sfd_i, // receive frame start pulse
    input wire logic rx_byte_valid_i, // receive byte strobe
    input wire logic [7:0] rx_byte_i, // receive byte
    input wire logic [7:0] rx_status_i, // receive status for header
    input wire logic tx_start_i, // transmit command pulse
    input wire logic tx_sfd_i, // transmit passed frame start
    input wire logic tx_pop_i, // serializer takes a byte
    input wire logic tx_done_i, // transmit finished
    input wire logic remote_req_i, // remote dma wants one transfer
    input wire logic remote_write_i, // remote transfer writes memory
    input wire logic [15:0] remote_addr_i, // remote dma address
    input wire logic [15:0] remote_wdata_i, // remote write data
    input wire logic bus_grant_i, // arbiter grant
    input wire logic [15:0] data_i, // memory read data
    output logic bus_request_out_o, // bus request
    output logic [15:0] addr_o, // bus address
    output logic addr_strobe_o, // lower address strobe, first T state
    output logic upper_addr_strobe_o, // upper address strobe
    output logic upper_addr_strobe_oe_o, // upper strobe driven
    output logic mem_read_o, // memory read strobe
    output logic mem_write_o, // memory write strobe
    output logic [15:0] data_o, // memory write data
    output logic data_oe_o, // data bus driven
    output logic [7:0] tx_byte_o, // byte to serializer
    output logic [15:0] remote_rdata_o, // remote read data
    output logic remote_done_o, // remote transfer done pulse
    output logic [1:0] bus_mode_o, // reset, idle or master
    output logic fifo_error_o, // sticky fifo over/underflow
    output logic end_of_packet_processing_o // end of packet sequence running
);
    lbmd_pkg::lbmd_state_t state;
    lbmd_pkg::lbmd_state_t next_state;
    logic [1:0] tcnt, next_tcnt;
    logic [4:0] fill, burst_left, next_burst_left;
    logic [3:0] wptr, rptr;
    logic [15:0] laddr, next_laddr, rx_count;
    logic [8:0] sfd_cnt;
    logic is_remote, next_is_remote, is_hdr, next_is_hdr;
    logic rx_on, tx_on, prefetched, tx_past_sfd, carrier_d;
    logic [15:0] rd_data;

    wire [4:0] step, thr, take, wr_n, rd_n, next_fill, tx_room, rx_len, tx_len;
    wire [4:0] local_len, fill_left, hdr_idx;
    wire t_end, burst_done, bus_rd_fifo, bus_wr_fifo, net_wr, net_rd, fifo_err;
    wire sfd_done, addr_ok, rx_trig, rx_need, tx_need, local_need, start_hdr;
    wire rx_begin, tx_begin, hdr_done, busy_next, next_req, next_rd_cycle;
    wire eop;
    wire [15:0] hdr_w, out_word;
    lbmd_pkg::lbmd_state_t first_state;

    assign eop = end_of_packet_processing_o;
    assign step = cfg_word_i ? lbmd_pkg::WORD_STEP : lbmd_pkg::BYTE_STEP; // RULE_05
    assign thr = lbmd_pkg::burst_bytes(cfg_fifo_sel_i); // RULE_09
    assign take = lbmd_pkg::min5(burst_left, step);
    assign t_end = (state == lbmd_pkg::ST_XFER) && (tcnt == lbmd_pkg::T_LAST);
    assign burst_done = burst_left <= step;
    assign bus_rd_fifo = t_end && bus_grant_i && !is_remote && !is_hdr && rx_on;
    assign bus_wr_fifo = t_end && bus_grant_i && !is_remote && tx_on;
    assign net_wr = rx_on && rx_byte_valid_i;
    assign net_rd = tx_on && tx_pop_i;
    assign wr_n = bus_wr_fifo ? take : {4'h0, net_wr};
    assign rd_n = bus_rd_fifo ? take : {4'h0, net_rd};
    assign next_fill = fill + wr_n - rd_n;
    assign fill_left = fill - take;
    assign fifo_err = (next_fill >= lbmd_pkg::OVERRUN_FILL) // RULE_19
        || (net_rd && (fill == '0));
    assign sfd_done = sfd_cnt == '0; // RULE_16
    assign addr_ok = rx_count >= lbmd_pkg::ADDR_FIELD_BYTES; // RULE_15
    assign rx_trig = fill >= (thr + step); // RULE_20
    assign rx_need = rx_on && ((sfd_done && addr_ok && rx_trig) || eop); // RULE_14
    assign tx_room = lbmd_pkg::TX_FILL_MAX - fill;
    assign tx_need = tx_on && (tx_room != '0) // RULE_21
        && (!prefetched || (tx_past_sfd && (fill < thr)));
    assign local_need = rx_need || tx_need;
    assign rx_len = (eop || cfg_drain_all_i) ? fill : thr; // RULE_10
    assign tx_len = !prefetched ? thr
        : (cfg_drain_all_i ? tx_room : lbmd_pkg::min5(thr, tx_room));
    assign start_hdr = rx_on && eop && (fill == '0);
    assign local_len = start_hdr ? lbmd_pkg::HDR_BYTES : (rx_on ? rx_len : tx_len);
    assign first_state = cfg_addr32_i ? lbmd_pkg::ST_UPPER : lbmd_pkg::ST_XFER; // RULE_07
    assign rx_begin = rx_sfd_i && !tx_on && !rx_on && (state != lbmd_pkg::ST_RESET);
    assign tx_begin = tx_start_i && !tx_on && !rx_on && (state != lbmd_pkg::ST_RESET);
    assign hdr_done = t_end && bus_grant_i && is_hdr && burst_done;
    assign hdr_idx = lbmd_pkg::HDR_BYTES - burst_left;
    assign hdr_w = hdr_idx[1] ? rx_count : {lbmd_pkg::ZERO_BYTE, rx_status_i};
    assign out_word = is_remote ? remote_wdata_i
        : is_hdr ? (cfg_word_i ? hdr_w
            : {lbmd_pkg::ZERO_BYTE, hdr_idx[0] ? hdr_w[15:8] : hdr_w[7:0]})
        : (cfg_word_i && (take == lbmd_pkg::WORD_STEP)) ? rd_data
        : {lbmd_pkg::ZERO_BYTE, rd_data[7:0]};
    assign busy_next = (next_state == lbmd_pkg::ST_UPPER) || (next_state == lbmd_pkg::ST_XFER);
    // idle to idle only: leaving a transfer for idle drops the request one cycle; a local append keeps it
    assign next_req = busy_next || ((state == lbmd_pkg::ST_IDLE) // RULE_13
        && (next_state == lbmd_pkg::ST_IDLE) && (local_need || remote_req_i)); // RULE_04
    assign next_rd_cycle = next_is_remote ? !remote_write_i : (tx_on && !next_is_hdr);

    always_comb begin
        next_state = state;
        next_tcnt = tcnt;
        next_burst_left = burst_left;
        next_laddr = laddr;
        next_is_remote = is_remote;
        next_is_hdr = is_hdr;
        case (state)
            lbmd_pkg::ST_RESET: begin
                if (start_cmd_i) begin
                    next_state = lbmd_pkg::ST_IDLE; // RULE_03
                end
            end
            lbmd_pkg::ST_IDLE: begin
                if (bus_request_out_o && bus_grant_i) begin // RULE_23
                    next_state = first_state;
                    next_tcnt = lbmd_pkg::T_FIRST;
                    next_is_remote = !local_need; // RULE_12
                    next_is_hdr = start_hdr;
                    next_burst_left = local_need ? local_len : step;
                    if (start_hdr) begin
                        next_laddr = local_base_i;
                    end
                end
            end
            lbmd_pkg::ST_UPPER: begin
                next_tcnt = tcnt + 2'h1;
                if (!bus_grant_i) begin
                    next_state = lbmd_pkg::ST_IDLE; // RULE_11
                end else if (tcnt == lbmd_pkg::T_LAST) begin
                    next_state = lbmd_pkg::ST_XFER; // RULE_08
                end
            end
            lbmd_pkg::ST_XFER: begin
                next_tcnt = tcnt + 2'h1; // RULE_06
                if (!bus_grant_i) begin
                    next_state = lbmd_pkg::ST_IDLE; // RULE_11
                end else if (tcnt == lbmd_pkg::T_LAST) begin
                    if (!is_remote) begin
                        next_laddr = laddr + {11'h000, take};
                    end
                    next_burst_left = burst_left - take;
                    if (!burst_done) begin
                        next_state = lbmd_pkg::ST_XFER;
                    end else if (is_remote && local_need) begin
                        next_state = first_state; // RULE_13
                        next_is_remote = 1'b0;
                        next_is_hdr = start_hdr;
                        next_burst_left = local_len;
                        if (start_hdr) begin
                            next_laddr = local_base_i;
                        end
                    end else if (!is_remote && !is_hdr && rx_on && eop) begin
                        if (fill_left != '0) begin
                            next_burst_left = fill_left; // RULE_17
                        end else begin
                            next_is_hdr = 1'b1; // RULE_18
                            next_burst_left = lbmd_pkg::HDR_BYTES;
                            next_laddr = local_base_i;
                        end
                    end else begin
                        next_state = lbmd_pkg::ST_IDLE; // RULE_09
                    end
                end
            end
            default: next_state = lbmd_pkg::ST_RESET;
        endcase
        if (rx_begin) begin
            next_laddr = local_base_i + {11'h000, lbmd_pkg::HDR_BYTES};
        end
        if (tx_begin) begin
            next_laddr = local_base_i;
        end
        if (!rstn_i || stop_cmd_i || fifo_err) begin
            next_state = lbmd_pkg::ST_RESET; // RULE_02
        end
    end

    lbmd_fifo_mem u_mem (
        .clock_i(clock_i),
        .we_i(wr_n != '0),
        .two_i(wr_n == lbmd_pkg::WORD_STEP),
        .waddr_i(wptr),
        .wdata_i(bus_wr_fifo ? data_i : {lbmd_pkg::ZERO_BYTE, rx_byte_i}),
        .raddr_i(rptr + rd_n[3:0]),
        .rdata_o(rd_data)
    );

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state <= lbmd_pkg::ST_RESET; // RULE_01
            tcnt <= lbmd_pkg::T_FIRST;
            burst_left <= '0;
            laddr <= '0;
            is_remote <= 1'b0;
            is_hdr <= 1'b0;
        end else begin
            state <= next_state;
            tcnt <= next_tcnt;
            burst_left <= next_burst_left;
            laddr <= next_laddr;
            is_remote <= next_is_remote;
            is_hdr <= next_is_hdr;
        end
    end

    // fifo and packet flags; leaving to reset empties the fifo and disables both paths
    always_ff @(posedge clock_i) begin
        carrier_d <= rstn_i && carrier_sense_i;
        if (!rstn_i || next_state == lbmd_pkg::ST_RESET) begin
            fill <= '0; // RULE_01
            wptr <= '0;
            rptr <= '0;
            rx_on <= 1'b0;
            tx_on <= 1'b0;
            prefetched <= 1'b0;
            tx_past_sfd <= 1'b0;
            end_of_packet_processing_o <= 1'b0;
            sfd_cnt <= '0;
            rx_count <= '0;
        end else begin
            fill <= next_fill;
            wptr <= wptr + wr_n[3:0];
            rptr <= rptr + rd_n[3:0];
            if (rx_begin) begin
                rx_on <= 1'b1;
                sfd_cnt <= lbmd_pkg::SFD_DELAY_CNT; // RULE_16
                rx_count <= '0;
            end else begin
                if (!sfd_done) sfd_cnt <= sfd_cnt - 9'h001;
                if (net_wr) rx_count <= rx_count + 16'h0001;
            end
            if (rx_on && carrier_d && !carrier_sense_i) end_of_packet_processing_o <= 1'b1;
            if (hdr_done) begin
                rx_on <= 1'b0; // RULE_17
                end_of_packet_processing_o <= 1'b0;
            end
            if (tx_begin) begin
                tx_on <= 1'b1;
                prefetched <= 1'b0;
                tx_past_sfd <= 1'b0;
            end else if (tx_done_i) begin
                tx_on <= 1'b0;
            end
            if (tx_sfd_i && tx_on) tx_past_sfd <= 1'b1; // RULE_21
            if (bus_wr_fifo && burst_done) prefetched <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            bus_request_out_o <= 1'b0;
            addr_o <= '0;
            addr_strobe_o <= 1'b0;
            upper_addr_strobe_o <= 1'b0;
            upper_addr_strobe_oe_o <= 1'b0;
            mem_read_o <= 1'b0;
            mem_write_o <= 1'b0;
            data_o <= '0;
            data_oe_o <= 1'b0;
            tx_byte_o <= '0;
            remote_rdata_o <= '0;
            remote_done_o <= 1'b0;
            bus_mode_o <= lbmd_pkg::MODE_RESET;
            fifo_error_o <= 1'b0;
        end else begin
            bus_request_out_o <= next_req;
            addr_strobe_o <= (next_state == lbmd_pkg::ST_XFER) && (next_tcnt == lbmd_pkg::T_FIRST);
            upper_addr_strobe_o <= (next_state == lbmd_pkg::ST_UPPER)
                && (next_tcnt == lbmd_pkg::T_FIRST);
            upper_addr_strobe_oe_o <= next_state == lbmd_pkg::ST_UPPER; // RULE_08
            addr_o <= (next_state == lbmd_pkg::ST_UPPER) // RULE_07
                ? {remote_start_addr_high_i, remote_start_addr_low_i}
                : (next_is_remote ? remote_addr_i : next_laddr);
            mem_read_o <= (next_state == lbmd_pkg::ST_XFER)
                && (next_tcnt != lbmd_pkg::T_FIRST) && next_rd_cycle;
            mem_write_o <= (next_state == lbmd_pkg::ST_XFER)
                && (next_tcnt != lbmd_pkg::T_FIRST) && !next_rd_cycle;
            data_oe_o <= (next_state == lbmd_pkg::ST_XFER) && !next_rd_cycle;
            if (next_tcnt == lbmd_pkg::T_DATA) data_o <= out_word;
            if (net_rd) tx_byte_o <= rd_data[7:0];
            remote_done_o <= t_end && bus_grant_i && is_remote;
            if (t_end && is_remote && !remote_write_i) remote_rdata_o <= data_i;
            bus_mode_o <= (next_state == lbmd_pkg::ST_RESET) ? lbmd_pkg::MODE_RESET
                : (busy_next ? lbmd_pkg::MODE_MASTER : lbmd_pkg::MODE_IDLE);
            if (fifo_err) fifo_error_o <= 1'b1;
            else if (start_cmd_i) fifo_error_o <= 1'b0;
        end
    end

    wire ok_run;
    assign ok_run = !stop_cmd_i && !fifo_err && bus_grant_i;

    sequence t1_seen;
        state == lbmd_pkg::ST_XFER && tcnt == lbmd_pkg::T_FIRST && ok_run;
    endsequence
    sequence t_run;
        ok_run [*3];
    endsequence

    reset_state_a: assert property (@(posedge clock_i) // RULE_01
        !rstn_i |=> bus_mode_o == lbmd_pkg::MODE_RESET && !bus_request_out_o && !rx_on)
        else $error("reset does not reach reset state");
    stop_reset_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_02
        stop_cmd_i |=> state == lbmd_pkg::ST_RESET && !tx_on)
        else $error("stop does not reach reset state");
    start_idle_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_03
        state == lbmd_pkg::ST_RESET && start_cmd_i && !stop_cmd_i |=> state == lbmd_pkg::ST_IDLE)
        else $error("start does not enter idle");
    grant_start_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_23
        state == lbmd_pkg::ST_IDLE && bus_request_out_o && ok_run
        |=> bus_mode_o == lbmd_pkg::MODE_MASTER && (addr_strobe_o || upper_addr_strobe_o))
        else $error("grant not followed by first bus state");
    four_t_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_06
        t1_seen ##1 t_run |=> state == lbmd_pkg::ST_XFER && tcnt == lbmd_pkg::T_FIRST
        || state != lbmd_pkg::ST_XFER)
        else $error("bus transfer is not four clocks");
    upper_rel_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_08
        state == lbmd_pkg::ST_UPPER && tcnt == lbmd_pkg::T_LAST && ok_run
        |=> !upper_addr_strobe_oe_o && addr_strobe_o)
        else $error("upper strobe not released");
    grant_abort_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_11
        state == lbmd_pkg::ST_XFER && !bus_grant_i
        |=> !bus_request_out_o && bus_mode_o != lbmd_pkg::MODE_MASTER && !mem_write_o)
        else $error("burst not aborted on lost grant");
    append_keep_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_13
        t_end && is_remote && burst_done && local_need && ok_run
        |=> bus_request_out_o && !is_remote)
        else $error("request dropped while appending local burst");
    overrun_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_19
        rx_on && next_fill == lbmd_pkg::OVERRUN_FILL |=> fifo_error_o && !rx_on)
        else $error("thirteenth byte not flagged");
    first_req_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_15
        $rose(bus_request_out_o) && rx_on && !remote_req_i && !eop |-> addr_ok && sfd_done)
        else $error("receive request before address field");
    tx_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_21
        state == lbmd_pkg::ST_IDLE && tx_on && prefetched && !tx_past_sfd
        && !remote_req_i && !rx_on |=> !bus_request_out_o)
        else $error("transmit request before frame start");
endmodule : lbmd_bus_master

// [logic/lbmd_fifo_mem.sv]
// lbmd_fifo_mem: 16 x 8 fifo storage, one or two bytes written per edge.
// read data are registered: two bytes starting at the read address.
`timescale 1ns/100ps
module lbmd_fifo_mem (
    input wire logic clock_i, // local bus clock
    input wire logic we_i, // write enable
    input wire logic two_i, // write both bytes of wdata_i
    input wire logic [3:0] waddr_i, // first byte address
    input wire logic [15:0] wdata_i, // low byte goes first
    input wire logic [3:0] raddr_i, // read address
    output logic [15:0] rdata_o // {byte at raddr+1, byte at raddr}
);
    logic [7:0] mem [lbmd_pkg::FIFO_DEPTH];
    wire [3:0] waddr_nx;
    wire [3:0] raddr_nx;

    assign waddr_nx = waddr_i + 4'h1;
    assign raddr_nx = raddr_i + 4'h1;

    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i[7:0];
        end
        if (we_i && two_i) begin
            mem[waddr_nx] <= wdata_i[15:8];
        end
        rdata_o <= {mem[raddr_nx], mem[raddr_i]};
    end
endmodule : lbmd_fifo_mem

// [pkg/lbmd_pkg.sv]
// lbmd_pkg: constants, state type and helpers of the local bus master dma block.
// assumes a 50 MHz local bus clock and a 16-byte receive/transmit fifo.
package lbmd_pkg;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam logic [4:0] OVERRUN_FILL = 5'h0d;
    localparam logic [4:0] TX_FILL_MAX = 5'h0c;
    localparam logic [15:0] ADDR_FIELD_BYTES = 16'h0008;
    localparam logic [4:0] HDR_BYTES = 5'h04;
    localparam logic [4:0] BYTE_STEP = 5'h01;
    localparam logic [4:0] WORD_STEP = 5'h02;
    localparam logic [4:0] BURST_SEL0 = 5'h02;
    localparam logic [4:0] BURST_SEL1 = 5'h04;
    localparam logic [4:0] BURST_SEL2 = 5'h08;
    localparam logic [4:0] BURST_SEL3 = 5'h0c;
    localparam int T_STATES = 4;
    localparam logic [1:0] T_FIRST = 2'h0;
    localparam logic [1:0] T_DATA = 2'h1;
    localparam logic [1:0] T_LAST = 2'(T_STATES - 1);
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SFD_DELAY_NS = 7800;
    localparam int SFD_DELAY_CYC = (SFD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] SFD_DELAY_CNT = 9'(SFD_DELAY_CYC);
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] MODE_IDLE = 2'h1;
    localparam logic [1:0] MODE_MASTER = 2'h2;

    // gray codes along reset, idle, upper address cycle, transfer
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_IDLE = 2'h1,
        ST_UPPER = 2'h3,
        ST_XFER = 2'h2
    } lbmd_state_t;

    function automatic logic [4:0] burst_bytes(input logic [1:0] sel);
        case (sel)
            2'h0: burst_bytes = BURST_SEL0;
            2'h1: burst_bytes = BURST_SEL1;
            2'h2: burst_bytes = BURST_SEL2;
            default: burst_bytes = BURST_SEL3;
        endcase
    endfunction : burst_bytes

    function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
        min5 = (a < b) ? a : b;
    endfunction : min5
endpackage : lbmd_pkg

// [verif/lbmd_mem_model.sv]
// lbmd_mem_model: bus arbiter and byte-wide local buffer memory.
// assumes one master and byte-mode write transfers on clock_i.
`timescale 1ns/100ps
module lbmd_mem_model (
    input wire logic clock_i, // local bus clock
    input wire logic req_i, // bus request
    input wire logic hold_i, // withhold the grant
    input wire logic [15:0] addr_i, // bus address
    input wire logic rd_i, // memory read strobe
    input wire logic wr_i, // memory write strobe
    input wire logic [15:0] wdata_i, // memory write data
    output logic grant_o, // bus grant
    output logic [15:0] rdata_o // memory read data
);
    logic [7:0] mem [256];
    wire [15:0] word;
    initial grant_o = 1'b0;
    assign word = {mem[addr_i[7:0] + 8'h01], mem[addr_i[7:0]]};
    always @(posedge clock_i) begin
        grant_o <= #2 req_i && !hold_i;
        if (wr_i) mem[addr_i[7:0]] <= wdata_i[7:0];
    end
    // released bus shows the inverse so a sample outside the read is caught
    assign rdata_o = rd_i ? word : ~word;
endmodule : lbmd_mem_model

// [verif/tb.sv]
// tb: receive, remote and transmit paths of the bus master dma against the memory model.
// assumes byte mode and threshold 2; one remote read uses 32-bit addresses.
`timescale 1ns/100ps
module tb;
    logic clk = 0, rstn = 0, start = 0, stop = 0, crs = 0, sfd = 0, rv = 0;
    logic [7:0] rb = 8'h00;
    logic req, gnt, wr, end_of_packet_processing, rdone, ads1e, rd_en, ferr;
    logic a32 = 0, txs = 0, tsfd = 0, pop = 0, txd = 0, rreq = 0, rwr = 0, hold = 0;
    logic [7:0] txb, ral = 8'h34, rah = 8'h12;
    logic [15:0] base = 16'h0000, raddr = 16'h0040, rwd = 16'h00c3, rrd;
    logic [15:0] addr, wd, rd;
    logic [1:0] mode;
    int bad_count = 0, total_checks = 0, i;
    always #10 clk = ~clk;
    lbmd_bus_master lbmd_bus_master_inst (.clock_i(clk), .rstn_i(rstn), .start_cmd_i(start),
        .stop_cmd_i(stop), .cfg_addr32_i(a32), .cfg_word_i(1'b0), .cfg_fifo_sel_i(2'h0),
        .cfg_drain_all_i(1'b0), .remote_start_addr_low_i(ral),
        .remote_start_addr_high_i(rah), .local_base_i(base), .carrier_sense_i(crs),
        .rx_sfd_i(sfd), .rx_byte_valid_i(rv), .rx_byte_i(rb), .rx_status_i(8'h5a),
        .tx_start_i(txs), .tx_sfd_i(tsfd), .tx_pop_i(pop), .tx_done_i(txd),
        .remote_req_i(rreq), .remote_write_i(rwr), .remote_addr_i(raddr),
        .remote_wdata_i(rwd), .bus_grant_i(gnt), .data_i(rd), .bus_request_out_o(req),
        .addr_o(addr), .addr_strobe_o(), .upper_addr_strobe_o(),
        .upper_addr_strobe_oe_o(ads1e), .mem_read_o(rd_en), .mem_write_o(wr), .data_o(wd),
        .data_oe_o(), .tx_byte_o(txb), .remote_rdata_o(rrd), .remote_done_o(rdone),
        .bus_mode_o(mode), .fifo_error_o(ferr), .end_of_packet_processing_o(end_of_packet_processing));
    lbmd_mem_model lbmd_mem_model_inst (.clock_i(clk), .req_i(req), .hold_i(hold),
        .addr_i(addr), .rd_i(rd_en), .wr_i(wr), .wdata_i(wd), .grant_o(gnt), .rdata_o(rd));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    initial begin
        #60000;
        bad_count++;
        summarize();
    end
    initial begin
        step(2);
        rstn = 1;
        step(1);
        chk("bus_mode", 16'(2'h0), 16'(mode));
        start = 1;
        step(1);
        start = 0;
        step(1);
        chk("bus_mode", 16'(2'h1), 16'(mode));
        sfd = 1;
        step(1);
        sfd = 0;
        crs = 1;
        for (i = 0; i < 10; i++) begin
            rv = 1;
            rb = 8'(8'h10 + i);
            step(1);
            rv = 0;
            step(1);
        end
        step(360);
        chk("early_req", 16'h0000, 16'(req));
        for (i = 0; i < 20 && req !== 1'b1; i++) step(1);
        chk("first_req", 16'h0001, 16'(req));
        step(200);
        chk("byte0", 16'h0010, 16'(lbmd_mem_model_inst.mem[4]));
        chk("byte1", 16'h0011, 16'(lbmd_mem_model_inst.mem[5]));
        crs = 0;
        for (i = 0; i < 400 && end_of_packet_processing !== 1'b1; i++) step(1);
        for (i = 0; i < 400 && end_of_packet_processing !== 1'b0; i++) step(1);
        step(2);
        chk("last_byte", 16'h0019, 16'(lbmd_mem_model_inst.mem[13]));
        chk("header", 16'h005a, 16'(lbmd_mem_model_inst.mem[0]));
        chk("req_off", 16'h0000, 16'(req));
        chk("count_low", 16'h000a, 16'(lbmd_mem_model_inst.mem[2]));
        rreq = 1;
        rwr = 1;
        for (i = 0; i < 20 && mode !== 2'h2; i++) step(1);
        hold = 1;
        step(1);
        hold = 0;
        step(1);
        chk("abort_mode", 16'h0001, 16'(mode));
        for (i = 0; i < 40 && rdone !== 1'b1; i++) step(1);
        rreq = 0;
        chk("remote_wr", 16'h00c3, 16'(lbmd_mem_model_inst.mem[64]));
        step(2);
        a32 = 1;
        rwr = 0;
        rreq = 1;
        for (i = 0; i < 20 && ads1e !== 1'b1; i++) step(1);
        chk("upper_addr", 16'h1234, addr);
        for (i = 0; i < 40 && rdone !== 1'b1; i++) step(1);
        rreq = 0;
        a32 = 0;
        chk("remote_rd", 16'h00c3, 16'(rrd[7:0]));
        base = 16'h0004;
        txs = 1;
        step(1);
        txs = 0;
        step(30);
        chk("tx_hold", 16'h0000, 16'(req));
        tsfd = 1;
        step(1);
        tsfd = 0;
        pop = 1;
        step(1);
        pop = 0;
        chk("tx_byte0", 16'h0010, 16'(txb));
        step(30);
        pop = 1;
        step(1);
        pop = 0;
        chk("tx_byte1", 16'h0011, 16'(txb));
        txd = 1;
        step(1);
        txd = 0;
        chk("fifo_err", 16'h0000, 16'(ferr));
        stop = 1;
        step(1);
        stop = 0;
        step(1);
        chk("bus_mode", 16'(2'h0), 16'(mode));
        summarize();
    end
endmodule : tb
